// ===== ctg_bench.sv
// Self-checking bench for the camera timer and counter group
`timescale 1ns/1ns
`default_nettype none
module ctg_bench
  import ctg_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic count_clear_evt_in = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] trig_in = 4'h0;
  wire logic hready;
  wire logic hreadyout;
  wire logic hresp;
  wire logic timer_out;
  wire logic count_terminal_event;
  wire logic irq;
  wire logic [31:0] hrdata;
  int error_cnt = 0;
  int total_checks = 0;
  int term_seen = 0;
  int m_cnt = 0;
  int m_term = 0;
  int cterm = 4;
  int tw;
  int tl;
  int k;
  int j;
  bit m_run = 1'b0;
  bit m_self = 1'b0;
  bit go;

  // The single slave's ready is the bus ready
  assign hready = hreadyout;
  always #25 hclk = ~hclk;
  always @(posedge hclk) if (count_terminal_event === 1'b1) term_seen++;

  ctg_top #(.CW(32)) ctg_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trig_in(trig_in),
    .count_clear_evt_in(count_clear_evt_in), .timer_out(timer_out),
    .count_terminal_event(count_terminal_event), .irq(irq));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Waits on ready are bounded so a stuck slave ends the run
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    n = 0;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
    if (n >= 100) begin error_cnt++; close_out(); end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  task automatic wait_hi(output int d);
    d = 0;
    do begin @(posedge hclk); d++; end while (timer_out !== 1'b1 && d < tw * 20 + 40);
  endtask

  task automatic ttest(input logic v, input bit start);
    int d;
    int p;
    trig_in[0] <= v;
    wait_hi(d);
    if (!start) begin
      chk("no_start", {31'h0, timer_out}, 32'h0);
      return;
    end
    // A pulse that never comes or never ends is a hang: count it and stop
    if (timer_out !== 1'b1) begin error_cnt++; close_out(); end
    p = 0;
    do begin @(posedge hclk); p++; end while (timer_out === 1'b1 && p < tl * 20 + 40);
    if (timer_out === 1'b1) begin error_cnt++; close_out(); end
    chk("start_delay", 32'(d >= tw * 20 + 1 && d <= tw * 20 + 5), 32'h1);
    chk("pulse_len", 32'(p >= tl * 20 && p <= tl * 20 + 3), 32'h1);
    tick(2);
    chk("irq_set", {31'h0, irq}, 32'h1);
    rdc("elapsed", OFS_TELAPSED, tl);
    rdc("status_tend", OFS_STATUS, 32'h1);
    rdc("status_clr", OFS_STATUS, 32'h0);
    chk("irq_clr", {31'h0, irq}, 32'h0);
  endtask

  // Model counts only edges that the running counter sees
  task automatic pulse();
    trig_in[1] <= 1'b1;
    tick(2);
    trig_in[1] <= 1'b0;
    tick(2);
    if (m_run) begin
      m_cnt++;
      if (m_cnt >= cterm) begin
        m_cnt = 0;
        m_term++;
        if (!m_self) m_run = 1'b0;
      end
    end
  endtask

  initial begin
    void'($urandom(32'h8B671571));
    tick(10);
    hresetn <= 1'b1;
    tick(1);
    rdc("ctrl_rst", OFS_CTRL, CTRL_RST);
    rdc("twait_rst", OFS_TWAIT, TWAIT_RST);
    rdc("tlen_rst", OFS_TLEN, TLEN_RST);
    rdc("cterm_rst", OFS_CTERM, CTERM_RST);
    rdc("mask_rst", OFS_MASK, 32'h0);
    rdc("status_rst", OFS_STATUS, 32'h0);
    wr(8'h28, 32'hFFFF_FFFF);
    rdc("unmapped", 8'h28, 32'h0);
    tw = $urandom_range(2);
    tl = 1 + $urandom_range(2);
    wr(OFS_TWAIT, tw);
    wr(OFS_TLEN, tl);
    wr(OFS_MASK, 32'h3);
    rdc("mask", OFS_MASK, 32'h3);
    // Each mode sees a rising then a falling edge
    for (k = 0; k < 3; k++) begin
      wr(OFS_CTRL, k);
      for (j = 0; j < 2; j++) begin
        go = (k == 2) || (k == 0 && trig_in[0] == 1'b0) || (k == 1 && trig_in[0] == 1'b1);
        ttest(~trig_in[0], go);
      end
    end
    // Clear in mid-pulse, then a fresh edge restarts it
    trig_in[0] <= ~trig_in[0];
    wait_hi(j);
    if (timer_out !== 1'b1) begin error_cnt++; close_out(); end
    rdc("run_pulse", OFS_RUN, 32'h1);
    wr(OFS_CMD, 32'h1);
    tick(2);
    chk("clr_out", {31'h0, timer_out}, 32'h0);
    rdc("clr_elapsed", OFS_TELAPSED, 32'h0);
    rdc("clr_run", OFS_RUN, 32'h0);
    ttest(~trig_in[0], 1'b1);
    // Counter with start origin off
    wr(OFS_CTERM, cterm);
    wr(OFS_CTRL, 32'h50);
    pulse();
    rdc("off_idle", OFS_CCUR, m_cnt);
    wr(OFS_CMD, 32'h2);
    m_run = 1'b1;
    pulse();
    pulse();
    rdc("off_count", OFS_CCUR, m_cnt);
    wr(OFS_CMD, 32'h2);
    m_cnt = 0;
    pulse();
    rdc("off_restart", OFS_CCUR, m_cnt);
    wr(OFS_CTRL, 32'h150);
    count_clear_evt_in <= 1'b1;
    tick(2);
    count_clear_evt_in <= 1'b0;
    m_cnt = 0;
    m_run = 1'b0;
    pulse();
    rdc("evt_halt", OFS_CCUR, m_cnt);
    wr(OFS_CTRL, 32'h250);
    wr(OFS_CMD, 32'h2);
    m_run = 1'b1;
    repeat (cterm + 1) pulse();
    rdc("end_halt", OFS_CCUR, m_cnt);
    chk("term_evts", term_seen, m_term);
    rdc("status_cend", OFS_STATUS, 32'h2);
    // Self-restarting counter
    wr(OFS_CTRL, 32'h290);
    wr(OFS_CTRL, 32'h2D0);
    // Self start lands one cycle after the write; an edge before it is not counted
    tick(1);
    m_self = 1'b1;
    m_run = 1'b1;
    repeat (cterm + 1 + $urandom_range(3)) pulse();
    rdc("self_count", OFS_CCUR, m_cnt);
    chk("self_terms", term_seen, m_term);
    wr(OFS_CMD, 32'h2);
    m_cnt = 0;
    pulse();
    rdc("self_clr", OFS_CCUR, m_cnt);
    wr(OFS_CTRL, 32'h290);
    m_run = 1'b0;
    pulse();
    rdc("inactive", OFS_CCUR, m_cnt);
    close_out();
  end
endmodule
`default_nettype wire

// ===== ctg_pkg.sv
// Constants and types of the camera timer and counter group
package ctg_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TWAIT = 8'h04;
  localparam logic [7:0] OFS_TLEN = 8'h08;
  localparam logic [7:0] OFS_TELAPSED = 8'h0C;
  localparam logic [7:0] OFS_CTERM = 8'h10;
  localparam logic [7:0] OFS_CCUR = 8'h14;
  localparam logic [7:0] OFS_CMD = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_MASK = 8'h20;
  localparam logic [7:0] OFS_RUN = 8'h24;
  localparam int CMD_TCLR_BIT = 0;
  localparam int CMD_CCLR_BIT = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] TWAIT_RST = 32'h0000_0000;
  localparam logic [31:0] TLEN_RST = 32'h0000_0001;
  localparam logic [31:0] CTERM_RST = 32'h0000_0001;
  typedef enum logic [1:0] {
    EDGE_RISE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_EITHER = 2'b10
  } ctg_edge_t;
  typedef enum logic {
    CORIG_OFF = 1'b0,
    CORIG_SELF = 1'b1
  } ctg_corig_t;
  typedef enum logic [1:0] {
    CLR_NONE = 2'b00,
    CLR_EVENT = 2'b01,
    CLR_END = 2'b10
  } ctg_clr_t;
  typedef enum logic [1:0] {
    TM_IDLE = 2'b00,
    TM_WAIT = 2'b01,
    TM_PULSE = 2'b10
  } ctg_tstate_t;
  typedef struct packed {
    logic [21:0] rsvd;
    ctg_clr_t clr_origin;
    ctg_corig_t trig_origin;
    logic count_active;
    logic [1:0] count_src;
    logic [1:0] timer_src;
    ctg_edge_t edge_mode;
  } ctg_ctrl_t;
  typedef struct packed {
    logic count_end;
    logic timer_end;
  } ctg_evt_t;
endpackage

// ===== ctg_top.sv
// Camera timer and counter group with AHB-Lite register slave
//
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module ctg_top
  import ctg_pkg::*;
#(
  parameter int CW = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [3:0] trig_in,
  input wire logic count_clear_evt_in,
  output logic timer_out,
  output logic count_terminal_event,
  output logic irq
);
  if (CW < 8 || CW > 32) begin : g_chk
    $error("CW must lie between 8 and 32");
  end

  ctg_ctrl_t ctrl_q;
  logic [CW-1:0] twait_q, tlen_q, cterm_q;
  ctg_evt_t status_q, mask_q;
  logic [7:0] addr_q;
  logic wr_q;
  ctg_tstate_t tstate_q;
  logic [CW-1:0] us_q, cnt_q;
  logic [4:0] pre_q;
  logic tsel_prev_q, csel_prev_q, cevt_prev_q;
  logic cnt_run_q;

  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  logic take, wr_en, rd_en;
  assign take = hsel && htrans[1] && hready;
  assign rd_en = take && !hwrite;
  assign wr_en = wr_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 8'h00;
      wr_q <= 1'b0;
    end else begin
      wr_q <= take && hwrite && hsize == 3'b010;
      if (take) begin
        addr_q <= {haddr[7:2], 2'b00};
      end
    end
  end

  logic cmd_tclr, cmd_cclr;
  assign cmd_tclr = wr_en && addr_q == OFS_CMD && hwdata[CMD_TCLR_BIT];
  assign cmd_cclr = wr_en && addr_q == OFS_CMD && hwdata[CMD_CCLR_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= ctg_ctrl_t'(CTRL_RST);
      twait_q <= CW'(TWAIT_RST);
      tlen_q <= CW'(TLEN_RST);
      cterm_q <= CW'(CTERM_RST);
      mask_q <= ctg_evt_t'(2'b00);
    end else if (wr_en) begin
      unique case (addr_q)
        OFS_CTRL: ctrl_q <= ctg_ctrl_t'({22'h000000, hwdata[9:0]});
        OFS_TWAIT: twait_q <= hwdata[CW-1:0];
        OFS_TLEN: tlen_q <= hwdata[CW-1:0];
        OFS_CTERM: cterm_q <= hwdata[CW-1:0];
        OFS_MASK: mask_q <= ctg_evt_t'(hwdata[1:0]);
        default: ;
      endcase
    end
  end

  logic [CW-1:0] elapsed;
  assign elapsed = (tstate_q == TM_WAIT) ? '0 : us_q;
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case ({haddr[7:2], 2'b00})
      OFS_CTRL: rd_val = 32'(ctrl_q);
      OFS_TWAIT: rd_val = 32'(twait_q);
      OFS_TLEN: rd_val = 32'(tlen_q);
      OFS_TELAPSED: rd_val = 32'(elapsed);
      OFS_CTERM: rd_val = 32'(cterm_q);
      OFS_CCUR: rd_val = 32'(cnt_q);
      OFS_STATUS: rd_val = 32'(status_q);
      OFS_MASK: rd_val = 32'(mask_q);
      OFS_RUN: rd_val = {29'h0, cnt_run_q, tstate_q == TM_WAIT, tstate_q == TM_PULSE};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Read data is sampled at the address phase so the data phase sees a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_en) begin
      hrdata <= rd_val;
    end
  end

  // Start edge selection
  logic tsel, trig;
  assign tsel = trig_in[ctrl_q.timer_src];
  always_comb begin
    trig = 1'b0;
    unique case (ctrl_q.edge_mode)
      EDGE_RISE: trig = tsel && !tsel_prev_q;
      EDGE_FALL: trig = !tsel && tsel_prev_q;
      EDGE_EITHER: trig = tsel != tsel_prev_q;
      default: trig = 1'b0;
    endcase
  end

  logic tick, tend;
  assign tick = pre_q == 5'(US_CYCLES - 1);
  assign tend = tstate_q == TM_PULSE && !cmd_tclr && us_q >= tlen_q;

  // Timer: the wait and the pulse share one microsecond counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tstate_q <= TM_IDLE;
      us_q <= '0;
      pre_q <= 5'h00;
      tsel_prev_q <= 1'b0;
    end else begin
      tsel_prev_q <= tsel;
      pre_q <= tick ? 5'h00 : pre_q + 5'h01;
      unique case (tstate_q)
        TM_IDLE: begin
          if (trig && !cmd_tclr) begin
            tstate_q <= TM_WAIT;
            us_q <= '0;
            pre_q <= 5'h00;
          end else if (cmd_tclr) begin
            us_q <= '0;
          end
        end
        TM_WAIT: begin
          if (cmd_tclr) begin
            tstate_q <= TM_IDLE;
            us_q <= '0;
          end else if (us_q >= twait_q) begin
            tstate_q <= TM_PULSE;
            us_q <= '0;
            pre_q <= 5'h00;
          end else if (tick) begin
            us_q <= us_q + 1'b1;
          end
        end
        TM_PULSE: begin
          if (cmd_tclr) begin
            tstate_q <= TM_IDLE;
            us_q <= '0;
          end else if (tend) begin
            tstate_q <= TM_IDLE;
          end else if (tick) begin
            us_q <= us_q + 1'b1;
          end
        end
        default: begin
          tstate_q <= TM_IDLE;
          us_q <= '0;
        end
      endcase
    end
  end

  // Timer line follows the pulse state; a glitch-free flop output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_out <= 1'b0;
    end else begin
      timer_out <= (tstate_q == TM_WAIT && !cmd_tclr && us_q >= twait_q)
        || (tstate_q == TM_PULSE && !cmd_tclr && !tend);
    end
  end

  // Counter: counts rising edges of its selected input
  logic csel, cinc, cevt, cnt_hit, off_org;
  assign csel = trig_in[ctrl_q.count_src];
  assign cinc = csel && !csel_prev_q;
  assign cevt = count_clear_evt_in && !cevt_prev_q;
  assign off_org = ctrl_q.trig_origin == CORIG_OFF;
  assign cnt_hit = ctrl_q.count_active && cnt_run_q && cinc && !cmd_cclr
    && ({1'b0, cnt_q} + 1'b1 >= {1'b0, cterm_q});

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
      cnt_run_q <= 1'b0;
      csel_prev_q <= 1'b0;
      cevt_prev_q <= 1'b0;
    end else begin
      csel_prev_q <= csel;
      cevt_prev_q <= count_clear_evt_in;
      if (!ctrl_q.count_active) begin
        cnt_run_q <= 1'b0;
      end else if (cmd_cclr) begin
        cnt_q <= '0;
        cnt_run_q <= 1'b1;
      end else if (!off_org && !cnt_run_q) begin
        cnt_run_q <= 1'b1;
      end else if (ctrl_q.clr_origin == CLR_EVENT && cevt) begin
        cnt_q <= '0;
        cnt_run_q <= !off_org;
      end else if (cnt_hit) begin
        cnt_q <= '0;
        cnt_run_q <= !(off_org && ctrl_q.clr_origin == CLR_END);
      end else if (cnt_run_q && cinc) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign count_terminal_event = cnt_hit;

  // Sticky events; a new event beats the read that clears it
  ctg_evt_t set_ev;
  logic st_rd;
  assign set_ev = '{count_end: cnt_hit, timer_end: tend};
  assign st_rd = rd_en && {haddr[7:2], 2'b00} == OFS_STATUS;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= ctg_evt_t'(2'b00);
    end else begin
      status_q <= (st_rd ? ctg_evt_t'(2'b00) : status_q) | set_ev;
    end
  end
  assign irq = |(status_q & mask_q);

  a_rise_start: assert property (@(posedge hclk) disable iff (!hresetn)
    tstate_q == TM_IDLE && ctrl_q.edge_mode == EDGE_RISE && tsel && !tsel_prev_q
    && !cmd_tclr |=> tstate_q == TM_WAIT)
    else $error("rising edge did not start timer");
  a_fall_start: assert property (@(posedge hclk) disable iff (!hresetn)
    tstate_q == TM_IDLE && ctrl_q.edge_mode == EDGE_FALL && !tsel && tsel_prev_q
    && !cmd_tclr |=> tstate_q == TM_WAIT)
    else $error("falling edge did not start timer");
  a_either_start: assert property (@(posedge hclk) disable iff (!hresetn)
    tstate_q == TM_IDLE && ctrl_q.edge_mode == EDGE_EITHER
    && $changed(tsel) && !cmd_tclr |=> tstate_q == TM_WAIT)
    else $error("either edge did not start timer");
  a_wait_early: assert property (@(posedge hclk) disable iff (!hresetn)
    tstate_q == TM_WAIT && us_q < twait_q |=> tstate_q != TM_PULSE)
    else $error("pulse began before the delay");
  a_pulse_end: assert property (@(posedge hclk) disable iff (!hresetn)
    tstate_q == TM_PULSE && us_q >= tlen_q && !cmd_tclr
    |=> tstate_q == TM_IDLE && status_q.timer_end)
    else $error("pulse did not end at its length");
  a_elapsed_rd: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_en && {haddr[7:2], 2'b00} == OFS_TELAPSED
    |=> hrdata == 32'($past(elapsed)))
    else $error("elapsed read wrong");
  a_tclr_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_tclr && tstate_q != TM_IDLE |=> tstate_q == TM_IDLE && us_q == '0)
    else $error("timer clear failed");
  a_off_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    off_org && !cnt_run_q && !cmd_cclr |=> !cnt_run_q)
    else $error("counter started without command");
  a_cclr_run: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_cclr && ctrl_q.count_active |=> cnt_q == '0 && cnt_run_q)
    else $error("clear command did not restart counter");
  a_off_halt: assert property (@(posedge hclk) disable iff (!hresetn)
    off_org && cnt_hit && ctrl_q.clr_origin == CLR_END |=> !cnt_run_q ##1 !cnt_run_q
    || $past(cmd_cclr))
    else $error("counter did not halt at end");
  a_self_go: assert property (@(posedge hclk) disable iff (!hresetn)
    !off_org && ctrl_q.count_active && $stable(ctrl_q) |=> cnt_run_q)
    else $error("self mode did not start");
  a_self_clr: assert property (@(posedge hclk) disable iff (!hresetn)
    !off_org && cmd_cclr && ctrl_q.count_active |=> cnt_run_q && cnt_q == '0)
    else $error("self clear did not continue");
  a_term_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    cnt_hit |=> cnt_q == '0 && status_q.count_end)
    else $error("terminal count not handled");
  a_out_shape: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(timer_out) |-> $past(tstate_q) == TM_PULSE)
    else $error("timer output fell outside a pulse");
  c_pulse: cover property (@(posedge hclk) disable iff (!hresetn) $fell(timer_out));
  c_term: cover property (@(posedge hclk) disable iff (!hresetn) cnt_hit);
  c_tclr: cover property (@(posedge hclk) disable iff (!hresetn)
    cmd_tclr && tstate_q == TM_PULSE);
  c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
endmodule
`default_nettype wire
